// >>> logic/eps_defines.svh
// timing, value and count constants for the eprom program sequencer
`ifndef EPS_DEFINES_SVH
`define EPS_DEFINES_SVH
`define EPS_CLK_MHZ      10
`define EPS_IMP_W_US     2500
`define EPS_IMP_DUTY_PM  190
`define EPS_ORG_W_US     10000
`define EPS_ORG_DUTY_PM  19
`define EPS_PM_SCALE     1000
`define EPS_ORG_PASSES   8'h0a
`define EPS_SMART_PASSES 8'h00
`define EPS_IMP_BLANK    8'h00
`define EPS_ORG_BLANK    8'hff
`define EPS_MAX_P        9'h100
`define EPS_FULL_RANGE   9'h100
`define EPS_OVER_SHIFT   2
`define EPS_READ_WAIT    3'h3
`define EPS_PULSE_W      23
`endif

// >>> logic/eps_pkg.sv
// types shared by the eprom program sequencer
package eps_pkg;
	typedef enum logic [3:0] {
		S_IDLE   = 4'h0,
		S_CONF   = 4'h1,
		S_READ   = 4'h2,
		S_EVAL   = 4'h3,
		S_WR     = 4'h4,
		S_PSTART = 4'h5,
		S_PULSE  = 4'h6,
		S_BEGIN  = 4'h7
	} eps_state_t;
	typedef enum logic [2:0] {
		K_BLANK = 3'h0,
		K_VERI  = 3'h1,
		K_ABS   = 3'h2,
		K_PASS  = 3'h3,
		K_MATCH = 3'h4
	} eps_kind_t;
	typedef enum logic [1:0] {
		PH_SIMPLE = 2'h0,
		PH_FIND   = 2'h1,
		PH_OVER   = 2'h2
	} eps_phase_t;
	typedef struct packed {
		logic       part_orig;
		logic       smart;
		logic [7:0] passes;
	} eps_settings_t;
	typedef struct packed {
		logic       mark;
		logic       mismatch;
		logic       nonblank;
		logic       fail;
		logic       match;
		logic       p_report;
		logic       range_err;
		logic       absent_warn;
		logic       aborted;
		logic [7:0] addr;
		logic [7:0] buf_val;
		logic [7:0] eprom_val;
		logic [8:0] p;
	} eps_report_t;
endpackage

// >>> logic/eps_pulse_gen.sv
// program pulse generator: width high, then low until the period ends
`timescale 1ns/100ps
module eps_pulse_gen #(
	parameter int CW = 23
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          start,
	input  wire logic [CW-1:0] width_cyc,
	input  wire logic [CW-1:0] period_cyc,
	output logic               pulse,
	output logic               done
);
	logic [CW-1:0] cnt_q;
	logic          run_q;
	logic          pulse_q;
	wire           last = run_q && (cnt_q == period_cyc - CW'(1));
	wire           w_end = run_q && (cnt_q == width_cyc - CW'(1));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q   <= '0;
			run_q   <= 1'b0;
			pulse_q <= 1'b0;
		end else begin
			cnt_q   <= (start || last) ? '0 : cnt_q + CW'(run_q);
			run_q   <= start ? 1'b1 : (last ? 1'b0 : run_q);
			pulse_q <= start ? 1'b1 : (w_end ? 1'b0 : pulse_q);
		end
	end

	assign pulse = pulse_q;
	assign done  = last;
endmodule // eps_pulse_gen

// >>> logic/eps_sequencer.sv
// eprom program sequencer: programming, compare and blank check
`timescale 1ns/100ps
`include "eps_defines.svh"

// Overview of operation
// - improved part: 2.5 ms program pulse at 19 percent duty
// - original part: 10 ms program pulse at 1.9 percent duty
// - nonzero pass count selects simple algorithm running that many passes
// - simple: write range once per pass, progress mark after each pass
// - after programming, verify range against buffer, report mismatches
// - pass count zero, also the reset default, selects smart algorithm
// - smart: write a pass, then compare; count P until range matches
// - match phase: buffer ones must be ones in part; extras ignored
// - no match after 256 passes reports an error and aborts
// - on match report P, then run 4P over passes with marks
// - improved part: skip pulse for target byte 00
// - original part: skip pulse for target byte ff
// - control-c from the operator stops the sequence cleanly
// - start and count give a subrange; count zero means 256 bytes
// - improved part: all bytes ff means reversed or absent, abort
// - show settings and wait for yes before programming
// - mismatch reports address, buffer and part values, then fail or match
// - load record data only when high address equals page value
// - selecting the original part sets pass count to 10
// - blank check: 00 blank for improved, ff for original; report others
module eps_sequencer #(
	parameter int unsigned IMP_W_CYC   = `EPS_IMP_W_US * `EPS_CLK_MHZ,
	parameter int unsigned IMP_PER_CYC = IMP_W_CYC * `EPS_PM_SCALE
		/ `EPS_IMP_DUTY_PM,
	parameter int unsigned ORG_W_CYC   = `EPS_ORG_W_US * `EPS_CLK_MHZ,
	parameter int unsigned ORG_PER_CYC = ORG_W_CYC * `EPS_PM_SCALE
		/ `EPS_ORG_DUTY_PM
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          program_command,
	input  wire logic          blank_check_command,
	input  wire logic          compare_command,
	input  wire logic          part_type_select,
	input  wire logic          part_type_wr,
	input  wire logic [7:0]    pass_count_setting,
	input  wire logic          pass_count_wr,
	input  wire logic [7:0]    page_value_setting,
	input  wire logic [7:0]    range_start,
	input  wire logic [7:0]    range_count,
	input  wire logic          answer_yes,
	input  wire logic          answer_no,
	input  wire logic          abort_req,
	input  wire logic          rec_wr,
	input  wire logic [15:0]   rec_addr,
	input  wire logic [7:0]    rec_data,
	input  wire logic [7:0]    eprom_rdata,
	output logic [7:0]         eprom_addr,
	output logic [7:0]         eprom_wdata,
	output logic               eprom_data_oe,
	output logic               program_pulse,
	output eps_pkg::eps_settings_t settings,
	output logic               confirm_req,
	output logic               busy,
	output eps_pkg::eps_report_t report
);
	localparam int PW = `EPS_PULSE_W;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	eps_pkg::eps_state_t  st_q, st_d;
	eps_pkg::eps_kind_t   kind_q, kind_d;
	eps_pkg::eps_phase_t  ph_q, ph_d;
	eps_pkg::eps_report_t rpt_q, rpt_d;
	logic [7:0]  addr_q, addr_d;
	logic [8:0]  left_q, left_d;
	logic [8:0]  p_q, p_d;
	logic [10:0] over_q, over_d;
	logic [7:0]  passes_q, passes_d;
	logic        any_q, any_d;
	logic        abort_q, abort_d;
	logic [2:0]  wait_q, wait_d;
	logic        oe_q, oe_d;
	logic [7:0]  wdata_q, wdata_d;
	logic        orig_q;
	logic [7:0]  pcnt_q;
	logic [7:0]  rd_s1_q, rd_s2_q;
	logic [7:0]  mem_q [256];

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	wire [7:0] buf_byte  = mem_q[addr_q];
	wire [7:0] ep_byte   = rd_s2_q;
	wire       smart     = (pcnt_q == `EPS_SMART_PASSES);
	wire [7:0] blank_val = orig_q ? `EPS_ORG_BLANK : `EPS_IMP_BLANK;
	wire       skip      = (buf_byte == blank_val);
	// zero count is the whole array
	wire [8:0] cnt9      = (range_count == 8'h00) ? `EPS_FULL_RANGE
		: {1'b0, range_count};
	wire       last      = (left_q == 9'h001);
	wire       idle      = (st_q == eps_pkg::S_IDLE);
	// only missing ones count in the match phase
	wire       miss_bits = |(buf_byte & ~ep_byte);
	wire       pstart    = (st_q == eps_pkg::S_PSTART);
	wire       pdone;
	wire [PW-1:0] w_sel = orig_q ? PW'(ORG_W_CYC) : PW'(IMP_W_CYC);
	wire [PW-1:0] p_sel = orig_q ? PW'(ORG_PER_CYC) : PW'(IMP_PER_CYC);

	function automatic logic differs(input eps_pkg::eps_kind_t k,
		input logic [7:0] b, input logic [7:0] e, input logic [7:0] bl);
		differs = (k == eps_pkg::K_BLANK) ? (e != bl) : (e != b);
	endfunction

	eps_pulse_gen #(.CW(PW)) u_pulse (
		.clk        (clk),
		.rst        (rst),
		.start      (pstart),
		.width_cyc  (w_sel),
		.period_cyc (p_sel),
		.pulse      (program_pulse),
		.done       (pdone)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic adv;
		logic go;
		eps_pkg::eps_kind_t nk;
		adv      = 1'b0;
		go       = 1'b0;
		nk       = kind_q;
		st_d     = st_q;
		kind_d   = kind_q;
		ph_d     = ph_q;
		addr_d   = addr_q;
		left_d   = left_q;
		p_d      = p_q;
		over_d   = over_q;
		passes_d = passes_q;
		any_d    = any_q;
		wait_d   = wait_q;
		oe_d     = oe_q;
		wdata_d  = wdata_q;
		rpt_d    = rpt_q;
		rpt_d.mark        = 1'b0;
		rpt_d.mismatch    = 1'b0;
		rpt_d.nonblank    = 1'b0;
		rpt_d.fail        = 1'b0;
		rpt_d.match       = 1'b0;
		rpt_d.p_report    = 1'b0;
		rpt_d.range_err   = 1'b0;
		rpt_d.absent_warn = 1'b0;
		rpt_d.aborted     = 1'b0;
		// abort request held until a clean stop point
		abort_d  = idle ? 1'b0 : (abort_q | abort_req);
		unique case (st_q)
			eps_pkg::S_IDLE: begin
				if (program_command) begin
					st_d = eps_pkg::S_CONF;
				end else if (blank_check_command) begin
					go = 1'b1;
					nk = eps_pkg::K_BLANK;
				end else if (compare_command) begin
					go = 1'b1;
					nk = eps_pkg::K_VERI;
				end
			end
			eps_pkg::S_CONF: begin
				if (answer_no || abort_req) begin
					st_d = eps_pkg::S_IDLE;
				end else if (answer_yes && !orig_q) begin
					go = 1'b1;
					nk = eps_pkg::K_ABS;
				end else if (answer_yes) begin
					st_d = eps_pkg::S_BEGIN;
				end
			end
			eps_pkg::S_BEGIN: begin
				p_d      = 9'h000;
				passes_d = pcnt_q;
				ph_d     = smart ? eps_pkg::PH_FIND : eps_pkg::PH_SIMPLE;
				go       = 1'b1;
				nk       = eps_pkg::K_PASS;
			end
			eps_pkg::S_READ: begin
				// settle time covers the two-stage pin sampler
				wait_d = wait_q - 3'h1;
				if (wait_q == 3'h0) begin
					st_d = eps_pkg::S_EVAL;
				end
			end
			eps_pkg::S_EVAL: begin
				adv = 1'b1;
				unique case (kind_q)
					eps_pkg::K_MATCH: begin
						if (miss_bits) begin
							any_d = 1'b1;
						end
					end
					eps_pkg::K_ABS: begin
						// any non-ff byte means a part is present
						if (ep_byte != `EPS_ORG_BLANK) begin
							any_d = 1'b1;
						end
					end
					default: begin
						if (differs(kind_q, buf_byte, ep_byte, blank_val)) begin
							any_d = 1'b1;
							rpt_d.mismatch  = (kind_q == eps_pkg::K_VERI);
							rpt_d.nonblank  = (kind_q == eps_pkg::K_BLANK);
							rpt_d.addr      = addr_q;
							rpt_d.buf_val   = buf_byte;
							rpt_d.eprom_val = ep_byte;
						end
					end
				endcase
			end
			eps_pkg::S_WR: begin
				if (skip) begin
					adv = 1'b1;
				end else begin
					oe_d    = 1'b1;
					wdata_d = buf_byte;
					st_d    = eps_pkg::S_PSTART;
				end
			end
			eps_pkg::S_PSTART: begin
				st_d = eps_pkg::S_PULSE;
			end
			eps_pkg::S_PULSE: begin
				// data stays driven through the low part of the period
				if (pdone) begin
					oe_d = 1'b0;
					adv  = 1'b1;
				end
			end
			default: begin
				st_d = eps_pkg::S_IDLE;
			end
		endcase

		if (adv && abort_d) begin
			// stop between bytes, never inside a pulse
			rpt_d.aborted = 1'b1;
			st_d = eps_pkg::S_IDLE;
		end else if (adv && !last) begin
			addr_d = addr_q + 8'h01;
			left_d = left_q - 9'h001;
			wait_d = `EPS_READ_WAIT;
			st_d   = (kind_q == eps_pkg::K_PASS) ? eps_pkg::S_WR
				: eps_pkg::S_READ;
		end else if (adv) begin
			unique case (kind_q)
				eps_pkg::K_ABS: begin
					// all ff: reversed or missing part
					if (any_d) begin
						st_d = eps_pkg::S_BEGIN;
					end else begin
						rpt_d.absent_warn = 1'b1;
						st_d = eps_pkg::S_IDLE;
					end
				end
				eps_pkg::K_PASS: begin
					rpt_d.mark = 1'b1;
					go = 1'b1;
					unique case (ph_q)
						eps_pkg::PH_SIMPLE: begin
							passes_d = passes_q - 8'h01;
							if (passes_q == 8'h01) begin
								nk = eps_pkg::K_VERI;
							end
						end
						eps_pkg::PH_FIND: begin
							p_d = p_q + 9'h001;
							nk  = eps_pkg::K_MATCH;
						end
						default: begin
							over_d = over_q - 11'h001;
							if (over_q == 11'h001) begin
								nk = eps_pkg::K_VERI;
							end
						end
					endcase
				end
				eps_pkg::K_MATCH: begin
					if (!any_d) begin
						// report P then 4P over passes
						rpt_d.p_report = 1'b1;
						rpt_d.p        = p_q;
						over_d = {2'b00, p_q} << `EPS_OVER_SHIFT;
						ph_d   = eps_pkg::PH_OVER;
						go     = 1'b1;
						nk     = eps_pkg::K_PASS;
					end else if (p_q == `EPS_MAX_P) begin
						rpt_d.range_err = 1'b1;
						st_d = eps_pkg::S_IDLE;
					end else begin
						go = 1'b1;
						nk = eps_pkg::K_PASS;
					end
				end
				default: begin
					rpt_d.fail  = any_d;
					rpt_d.match = !any_d;
					st_d = eps_pkg::S_IDLE;
				end
			endcase
		end

		if (go) begin
			// every scan covers the requested subrange
			kind_d = nk;
			addr_d = range_start;
			left_d = cnt9;
			any_d  = 1'b0;
			wait_d = `EPS_READ_WAIT;
			st_d   = (nk == eps_pkg::K_PASS) ? eps_pkg::S_WR
				: eps_pkg::S_READ;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q     <= eps_pkg::S_IDLE;
			kind_q   <= eps_pkg::K_BLANK;
			ph_q     <= eps_pkg::PH_SIMPLE;
			rpt_q    <= '0;
			addr_q   <= 8'h00;
			left_q   <= 9'h000;
			p_q      <= 9'h000;
			over_q   <= 11'h000;
			passes_q <= 8'h00;
			any_q    <= 1'b0;
			abort_q  <= 1'b0;
			wait_q   <= 3'h0;
			oe_q     <= 1'b0;
			wdata_q  <= 8'h00;
		end else begin
			st_q     <= st_d;
			kind_q   <= kind_d;
			ph_q     <= ph_d;
			rpt_q    <= rpt_d;
			addr_q   <= addr_d;
			left_q   <= left_d;
			p_q      <= p_d;
			over_q   <= over_d;
			passes_q <= passes_d;
			any_q    <= any_d;
			abort_q  <= abort_d;
			wait_q   <= wait_d;
			oe_q     <= oe_d;
			wdata_q  <= wdata_d;
		end
	end

	// settings change only while idle so a run sees one set
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			orig_q <= 1'b0;
			pcnt_q <= `EPS_SMART_PASSES;
		end else if (idle && part_type_wr) begin
			orig_q <= part_type_select;
			pcnt_q <= part_type_select ? `EPS_ORG_PASSES
				: `EPS_SMART_PASSES;
		end else if (idle && pass_count_wr) begin
			pcnt_q <= pass_count_setting;
		end
	end

	// part data pins are asynchronous to clk
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_s1_q <= 8'h00;
			rd_s2_q <= 8'h00;
		end else begin
			rd_s1_q <= eprom_rdata;
			rd_s2_q <= rd_s1_q;
		end
	end

	// records load only on a page match
	always_ff @(posedge clk) begin
		if (rec_wr && idle && rec_addr[15:8] == page_value_setting) begin
			mem_q[rec_addr[7:0]] <= rec_data;
		end
	end

	assign eprom_addr       = addr_q;
	assign eprom_wdata      = wdata_q;
	assign eprom_data_oe    = oe_q;
	assign settings.part_orig = orig_q;
	assign settings.smart   = smart;
	assign settings.passes  = pcnt_q;
	assign confirm_req      = (st_q == eps_pkg::S_CONF);
	assign busy             = !idle;
	assign report           = rpt_q;
endmodule // eps_sequencer

// >>> tb/eps_eprom_model.sv
// socketed part model: slow or stuck bit programming, absent part
`timescale 1ns/100ps
module eps_eprom_model (
	input  wire logic       clk,
	input  wire logic [7:0] eprom_addr,
	input  wire logic [7:0] eprom_wdata,
	input  wire logic       eprom_data_oe,
	input  wire logic       program_pulse,
	input  wire logic       orig,
	input  wire logic       absent,
	input  wire logic [9:0] slow,
	output logic      [7:0] eprom_rdata
);
	logic [7:0] mem [256];
	logic [9:0] hits [256];
	logic       pulse_q;
	task automatic fill(input logic [7:0] v);
		for (int i = 0; i < 256; i++) begin
			mem[i] = v;
			hits[i] = 10'h0;
		end
	endtask
	initial fill(8'h00);
	assign eprom_rdata = absent ? 8'hff
		: eprom_data_oe ? eprom_wdata : mem[eprom_addr];
	// bits move only away from erased
	always @(posedge clk) begin
		pulse_q <= program_pulse;
		if (pulse_q && !program_pulse && eprom_data_oe) begin
			hits[eprom_addr] = hits[eprom_addr] + 10'h1;
			if (hits[eprom_addr] >= slow)
				mem[eprom_addr] <= orig ? mem[eprom_addr] & eprom_wdata
					: mem[eprom_addr] | eprom_wdata;
		end
	end
endmodule // eps_eprom_model

// >>> tb/eps_sequencer_sva.sv
// port checker for the eprom program sequencer
`timescale 1ns/100ps
module eps_sequencer_sva #(
	parameter int unsigned IMP_W_CYC   = 4,
	parameter int unsigned IMP_PER_CYC = 10,
	parameter int unsigned ORG_W_CYC   = 6,
	parameter int unsigned ORG_PER_CYC = 20
) (
	input wire logic                   clk,
	input wire logic                   rst,
	input wire logic                   program_command,
	input wire logic                   part_type_select,
	input wire logic                   part_type_wr,
	input wire logic [7:0]             pass_count_setting,
	input wire logic                   pass_count_wr,
	input wire logic [7:0]             eprom_wdata,
	input wire logic                   eprom_data_oe,
	input wire logic                   program_pulse,
	input wire eps_pkg::eps_settings_t settings,
	input wire logic                   confirm_req,
	input wire logic                   busy
);
	// ----------------------------------------
	// pulse high time and spacing counters
	// ----------------------------------------
	logic [23:0] hi_q, per_q, w_exp, p_exp;
	assign w_exp = settings.part_orig ? 24'(ORG_W_CYC) : 24'(IMP_W_CYC);
	assign p_exp = settings.part_orig ? 24'(ORG_PER_CYC) : 24'(IMP_PER_CYC);
	// spacing saturates so the first pulse after reset never fails
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hi_q <= 24'h0;
			per_q <= 24'hffffff;
		end else begin
			hi_q <= program_pulse ? hi_q + 24'h1 : 24'h0;
			per_q <= (program_pulse && hi_q == 24'h0) ? 24'h1
				: per_q + {23'h0, per_q != 24'hffffff};
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_pulse_end;
		program_pulse ##1 !program_pulse;
	endsequence
	sequence s_ask;
		program_command && !busy;
	endsequence
	a_pulse_width: assert property (s_pulse_end |-> hi_q == w_exp)
		else $error("pulse width wrong");
	a_pulse_period: assert property (
		program_pulse && hi_q == 24'h0 |-> per_q >= p_exp)
		else $error("pulse spacing short");
	a_pulse_drives: assert property (program_pulse |-> eprom_data_oe)
		else $error("pulse without data");
	a_skip_blank: assert property ($rose(eprom_data_oe) |->
		eprom_wdata != (settings.part_orig ? 8'hff : 8'h00))
		else $error("erased byte written");
	a_confirm_req: assert property (s_ask |=> confirm_req && busy)
		else $error("no confirm request");
	a_confirm_quiet: assert property (confirm_req |->
		!eprom_data_oe && !program_pulse)
		else $error("drive before answer");
	a_orig_count: assert property (
		part_type_wr && part_type_select && !busy
		|=> settings.part_orig && settings.passes == 8'h0a)
		else $error("original part count");
	a_pass_count: assert property (
		pass_count_wr && !part_type_wr && !busy
		|=> settings.passes == $past(pass_count_setting)
		&& settings.smart == (settings.passes == 8'h00))
		else $error("pass count write");
endmodule // eps_sequencer_sva

bind eps_sequencer eps_sequencer_sva #(
	.IMP_W_CYC(IMP_W_CYC), .IMP_PER_CYC(IMP_PER_CYC),
	.ORG_W_CYC(ORG_W_CYC), .ORG_PER_CYC(ORG_PER_CYC)
) eps_sequencer_sva_i (
	.clk(clk), .rst(rst), .program_command(program_command),
	.part_type_select(part_type_select), .part_type_wr(part_type_wr),
	.pass_count_setting(pass_count_setting), .pass_count_wr(pass_count_wr),
	.eprom_wdata(eprom_wdata), .eprom_data_oe(eprom_data_oe),
	.program_pulse(program_pulse), .settings(settings),
	.confirm_req(confirm_req), .busy(busy)
);

// >>> tb/test_eps_sequencer.sv
// self-checking bench for the eprom program sequencer
`timescale 1ns/100ps
module test_eps_sequencer;
	localparam logic [7:0] MIS = 8'h80, NB = 8'h40, FAIL = 8'h20;
	localparam logic [7:0] MAT = 8'h10, PR = 8'h08, RE = 8'h04;
	localparam logic [7:0] AW = 8'h02, AB = 8'h01;
	logic clk, rst, pcmd, bcmd, ccmd, psel, pwr, cwr, yes, no, abt, rwr;
	logic oe, pls, creq, busy, absent, pls_q;
	logic [7:0] pcs, rs, rc, rdat, rd, ea, ewd, pg;
	logic [15:0] raddr;
	logic [9:0] slow;
	logic [7:0] bufm [256];
	eps_pkg::eps_settings_t st;
	eps_pkg::eps_report_t rep, n, nq [$];
	int err_total, cmp_count, marks, pulses;
	int cyc = 0;

	eps_sequencer #(.IMP_W_CYC(4), .IMP_PER_CYC(10), .ORG_W_CYC(6),
		.ORG_PER_CYC(20)) eps_sequencer_i (.clk(clk), .rst(rst),
		.program_command(pcmd), .blank_check_command(bcmd),
		.compare_command(ccmd), .part_type_select(psel),
		.part_type_wr(pwr), .pass_count_setting(pcs), .pass_count_wr(cwr),
		.page_value_setting(pg), .range_start(rs), .range_count(rc),
		.answer_yes(yes), .answer_no(no), .abort_req(abt), .rec_wr(rwr),
		.rec_addr(raddr), .rec_data(rdat), .eprom_rdata(rd),
		.eprom_addr(ea), .eprom_wdata(ewd), .eprom_data_oe(oe),
		.program_pulse(pls), .settings(st), .confirm_req(creq),
		.busy(busy), .report(rep));
	eps_eprom_model eps_eprom_model_i (.clk(clk), .eprom_addr(ea),
		.eprom_wdata(ewd), .eprom_data_oe(oe), .program_pulse(pls),
		.orig(st.part_orig), .absent(absent), .slow(slow),
		.eprom_rdata(rd));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [31:0] e, g);
		cmp_count++;
		if (e !== g) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic end_sim();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic note(input logic [7:0] f, a, e, input logic [8:0] p);
		eps_pkg::eps_report_t m;
		m = '0;
		m[40:33] = f;
		m.addr = a;
		m.buf_val = bufm[a];
		m.eprom_val = e;
		m.p = p;
		nq.push_back(m);
	endtask

	// one-cycle strobe, then an edge for its effect to land
	task automatic pl(input int k);
		@(posedge clk);
		case (k)
			0: pcmd <= 1'b1;
			1: bcmd <= 1'b1;
			2: ccmd <= 1'b1;
			3: yes <= 1'b1;
			4: no <= 1'b1;
			5: abt <= 1'b1;
			6: cwr <= 1'b1;
			default: pwr <= 1'b1;
		endcase
		@(posedge clk);
		{pcmd, bcmd, ccmd, yes, no, abt, cwr, pwr} <= 8'h00;
		@(posedge clk);
	endtask

	task automatic run(input int k, ans, ab, input logic [7:0] s, c);
		marks = 0;
		pulses = 0;
		rs <= s;
		rc <= c;
		pl(k);
		for (int i = 0; i < 20 && creq !== 1'b1 && k == 0; i++)
			@(posedge clk);
		if (k == 0)
			pl(ans);
		repeat (ab) @(posedge clk);
		if (ab > 0)
			pl(5);
		for (int i = 0; i < 20000 && busy !== 1'b0; i++)
			@(posedge clk);
		repeat (3) @(posedge clk);
		chk("notes left", 0, nq.size());
	endtask

	function automatic int nz(input logic [7:0] s, c, v);
		nz = 0;
		for (int i = 0; i < c; i++)
			nz += int'(bufm[8'(s + i)] != v);
	endfunction

	task automatic scan(input logic [7:0] bl, s, input int c, input logic b);
		logic [7:0] a, e;
		logic bad;
		bad = 1'b0;
		for (int i = 0; i < c; i++) begin
			a = s + 8'(i);
			e = eps_eprom_model_i.mem[a];
			if (b ? e != bl : e != bufm[a]) begin
				bad = 1'b1;
				note(b ? NB : MIS, a, e, 9'h0);
			end
		end
		note(bad ? FAIL : MAT, 8'h0, 8'h0, 9'h0);
	endtask

	always @(posedge clk) begin
		cyc++;
		pls_q <= pls;
		if (pls && !pls_q)
			pulses++;
		if (rep.mark === 1'b1)
			marks++;
		if (rst === 1'b0 && rep[40:33] !== 8'h00) begin
			n = nq.size() > 0 ? nq.pop_front() : '1;
			chk("flags", n[40:33], rep[40:33]);
			if (n.mismatch || n.nonblank)
				chk("where", {n.addr, n.eprom_val}, {rep.addr, rep.eprom_val});
			if (n.mismatch)
				chk("buffer", n.buf_val, rep.buf_val);
			if (n.p_report)
				chk("p", n.p, rep.p);
		end
		if (cyc == 40000) begin
			err_total++;
			end_sim();
		end
	end

	initial begin
		{pcmd, bcmd, ccmd, psel, pwr, cwr, yes, no, abt, rwr} = '0;
		{absent, pls_q} = '0;
		{pcs, rs, rc, rdat} = '0;
		raddr = 16'h0;
		slow = 10'h1;
		err_total = 0;
		cmp_count = 0;
		rst = 1'b1;
		void'($urandom(32'ha0c7));
		// page is random so the record load sees an arbitrary page value
		pg = 8'($urandom);
		for (int i = 0; i < 256; i++)
			bufm[i] = 8'($urandom);
		bufm[8'h10] = 8'h00;
		bufm[8'h20] = 8'h01;
		bufm[8'h41] = 8'hff;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("settings", 10'h100, st);
		// last record is for another page and must not land
		for (int i = 0; i < 257; i++) begin
			@(posedge clk);
			rwr <= 1'b1;
			raddr <= i < 256 ? {pg, 8'(i)} : {~pg, 8'h11};
			rdat <= i < 256 ? bufm[8'(i)] : ~bufm[8'h11];
		end
		@(posedge clk);
		rwr <= 1'b0;
		eps_eprom_model_i.mem[3] = 8'h5a;
		scan(8'h00, 8'h02, 4, 1'b1);
		run(1, 0, 0, 8'h02, 8'h04);
		eps_eprom_model_i.mem[0] = bufm[0];
		scan(8'h00, 8'hfe, 3, 1'b0);
		run(2, 0, 0, 8'hfe, 8'h03);
		eps_eprom_model_i.fill(8'h00);
		note(PR, 8'h0, 8'h0, 9'h001);
		note(MAT, 8'h0, 8'h0, 9'h0);
		run(0, 3, 0, 8'h10, 8'h08);
		chk("marks", 5, marks);
		chk("pulses", 5 * nz(8'h10, 8'h08, 8'h00), pulses);
		eps_eprom_model_i.fill(8'h00);
		slow = 10'h2;
		note(PR, 8'h0, 8'h0, 9'h002);
		note(MAT, 8'h0, 8'h0, 9'h0);
		run(0, 3, 0, 8'h10, 8'h08);
		chk("marks", 10, marks);
		slow = 10'h1;
		pcs <= 8'h03;
		pl(6);
		chk("settings", 10'h003, st);
		note(MAT, 8'h0, 8'h0, 9'h0);
		run(0, 3, 0, 8'h10, 8'h08);
		chk("marks", 3, marks);
		pcs <= 8'h00;
		pl(6);
		slow = 10'h3ff;
		note(RE, 8'h0, 8'h0, 9'h0);
		run(0, 3, 0, 8'h20, 8'h01);
		chk("pulses", 256, pulses);
		slow = 10'h1;
		note(AB, 8'h0, 8'h0, 9'h0);
		run(0, 3, 2000, 8'h00, 8'h00);
		chk("drive", 0, oe);
		run(0, 4, 0, 8'h00, 8'h00);
		chk("pulses", 0, pulses);
		absent = 1'b1;
		note(AW, 8'h0, 8'h0, 9'h0);
		run(0, 3, 0, 8'h30, 8'h04);
		chk("pulses", 0, pulses);
		absent = 1'b0;
		psel <= 1'b1;
		pl(7);
		chk("settings", 10'h20a, st);
		eps_eprom_model_i.fill(8'hff);
		scan(8'hff, 8'h00, 256, 1'b1);
		run(1, 0, 0, 8'h00, 8'h00);
		pcs <= 8'h02;
		pl(6);
		note(MAT, 8'h0, 8'h0, 9'h0);
		run(0, 3, 0, 8'h40, 8'h04);
		chk("pulses", 2 * nz(8'h40, 8'h04, 8'hff), pulses);
		end_sim();
	end
endmodule // test_eps_sequencer
